//--- usp_serial_port.sv
// asynchronous serial port with register port and edge interrupts
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "usp_cfg.svh"
module usp_serial_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic irq,
  output logic gpio28_txd,
  input wire logic gpio27_rxd
);
  import usp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [4:0] ctl_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_en_r;
  logic transmit_empty_flag;
  logic receive_full_flag;
  logic [7:0] received_byte_bits;
  logic [7:0] send_byte_bits;
  logic tx_load;
  logic rx_take;
  logic port_enable;
  logic rate_prescale_eighth;
  logic [2:0] rate_select;

  assign port_enable = ctl_r[`USP_CTL_ENABLE_BIT];
  assign rate_select = ctl_r[`USP_CTL_RATE_MSB:`USP_CTL_RATE_LSB];
  assign rate_prescale_eighth = ctl_r[`USP_CTL_PRESCALE_BIT];
  assign tx_load = wr && (addr == `USP_ADDR_DATA);
  assign rx_take = rd && (addr == `USP_ADDR_DATA);
  assign send_byte_bits = wdata[7:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_r <= `USP_CTL_RESET;
    end else if (wr && addr == `USP_ADDR_CONTROL) begin
      ctl_r <= wdata[4:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_en_r <= 2'h0;
    end else if (wr && addr == `USP_ADDR_IRQ_ENABLE) begin
      irq_en_r <= wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      unique case (addr)
        `USP_ADDR_CONTROL: rdata <= {11'h000, ctl_r};
        `USP_ADDR_FLAGS: rdata <= {14'h0000, receive_full_flag, transmit_empty_flag};
        `USP_ADDR_DATA: rdata <= {8'h00, received_byte_bits};
        `USP_ADDR_IRQ_STATUS: rdata <= {14'h0000, irq_stat_r};
        `USP_ADDR_IRQ_ENABLE: rdata <= {14'h0000, irq_en_r};
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // baud timing: oversample tick at 16x bit rate
  localparam int OVS = 16;
  logic [15:0] tick_div;
  logic [15:0] tick_cnt_r;
  logic tick;

  always_comb begin
    // cycles per sixteenth of a bit, rates are 115200 / k
    unique case (rate_select)
      3'd0: tick_div = 16'((`USP_CLK_HZ) / (`USP_BAUD_MAX_HZ * OVS));
      3'd1: tick_div = 16'((`USP_CLK_HZ * 2) / (`USP_BAUD_MAX_HZ * OVS));
      3'd2: tick_div = 16'((`USP_CLK_HZ * 3) / (`USP_BAUD_MAX_HZ * OVS));
      3'd3: tick_div = 16'((`USP_CLK_HZ * 4) / (`USP_BAUD_MAX_HZ * OVS));
      3'd4: tick_div = 16'((`USP_CLK_HZ * 6) / (`USP_BAUD_MAX_HZ * OVS));
      3'd5: tick_div = 16'((`USP_CLK_HZ * 8) / (`USP_BAUD_MAX_HZ * OVS));
      3'd6: tick_div = 16'((`USP_CLK_HZ * 12) / (`USP_BAUD_MAX_HZ * OVS));
      3'd7: tick_div = 16'((`USP_CLK_HZ * 16) / (`USP_BAUD_MAX_HZ * OVS));
    endcase
    if (rate_prescale_eighth) begin
      tick_div = 16'(tick_div * `USP_PRESCALE);
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !port_enable) begin
      tick_cnt_r <= 16'h0000;
    end else if (tick) begin
      tick_cnt_r <= 16'h0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
    end
  end
  assign tick = port_enable && (tick_cnt_r >= tick_div - 16'h0001);

  ////////////////////////////////////////////////////////////////////////////
  // transmitter
  usp_tx_state_t tx_st_r;
  logic [7:0] tx_hold_r;
  logic tx_hold_full_r;
  logic [7:0] tx_sh_r;
  logic [2:0] tx_bit_r;
  logic [3:0] tx_ph_r;
  logic tx_empty_d_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_hold_full_r <= 1'b0;
      tx_hold_r <= 8'h00;
    end else if (tx_load) begin
      tx_hold_full_r <= 1'b1;
      tx_hold_r <= send_byte_bits;
    end else if (tx_st_r == USP_TX_IDLE && tx_hold_full_r && tick) begin
      tx_hold_full_r <= 1'b0;
    end
  end
  assign transmit_empty_flag = !tx_hold_full_r;

  always_ff @(posedge clk) begin
    if (rst || !port_enable) begin
      tx_st_r <= USP_TX_IDLE;
      gpio28_txd <= 1'b1;
      tx_sh_r <= 8'h00;
      tx_bit_r <= 3'd0;
      tx_ph_r <= 4'd0;
    end else if (tick) begin
      tx_ph_r <= tx_ph_r + 4'd1;
      unique case (tx_st_r)
        USP_TX_IDLE: begin
          gpio28_txd <= 1'b1;
          tx_ph_r <= 4'd0;
          if (tx_hold_full_r) begin
            tx_sh_r <= tx_hold_r;
            tx_st_r <= USP_TX_START;
            gpio28_txd <= 1'b0;
          end
        end
        USP_TX_START: begin
          if (tx_ph_r == 4'd15) begin
            tx_st_r <= USP_TX_DATA;
            tx_bit_r <= 3'd0;
            gpio28_txd <= tx_sh_r[0];
          end
        end
        USP_TX_DATA: begin
          if (tx_ph_r == 4'd15) begin
            if (tx_bit_r == 3'd7) begin
              tx_st_r <= USP_TX_STOP;
              gpio28_txd <= 1'b1;
            end else begin
              tx_bit_r <= tx_bit_r + 3'd1;
              tx_sh_r <= {1'b0, tx_sh_r[7:1]};
              gpio28_txd <= tx_sh_r[1];
            end
          end
        end
        USP_TX_STOP: begin
          if (tx_ph_r == 4'd15) begin
            tx_st_r <= USP_TX_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver
  logic rxd_s1_r;
  logic rxd_s2_r;
  usp_rx_state_t rx_st_r;
  logic [7:0] rx_sh_r;
  logic [2:0] rx_bit_r;
  logic [3:0] rx_ph_r;
  logic rx_full_r;
  logic [7:0] rx_data_r;
  logic rx_done;

  always_ff @(posedge clk) begin
    if (rst) begin
      rxd_s1_r <= 1'b1;
      rxd_s2_r <= 1'b1;
    end else begin
      rxd_s1_r <= gpio27_rxd;
      rxd_s2_r <= rxd_s1_r;
    end
  end

  assign rx_done = tick && rx_st_r == USP_RX_STOP && rx_ph_r == 4'd15;

  always_ff @(posedge clk) begin
    if (rst || !port_enable) begin
      rx_st_r <= USP_RX_IDLE;
      rx_sh_r <= 8'h00;
      rx_bit_r <= 3'd0;
      rx_ph_r <= 4'd0;
    end else if (tick) begin
      rx_ph_r <= rx_ph_r + 4'd1;
      unique case (rx_st_r)
        USP_RX_IDLE: begin
          rx_ph_r <= 4'd0;
          if (!rxd_s2_r) begin
            rx_st_r <= USP_RX_START;
          end
        end
        USP_RX_START: begin
          if (rx_ph_r == 4'd7) begin
            if (rxd_s2_r) begin
              rx_st_r <= USP_RX_IDLE;
            end else begin
              rx_ph_r <= 4'd0;
              rx_bit_r <= 3'd0;
              rx_st_r <= USP_RX_DATA;
            end
          end
        end
        USP_RX_DATA: begin
          if (rx_ph_r == 4'd15) begin
            rx_sh_r <= {rxd_s2_r, rx_sh_r[7:1]};
            rx_bit_r <= rx_bit_r + 3'd1;
            if (rx_bit_r == 3'd7) begin
              rx_st_r <= USP_RX_STOP;
            end
          end
        end
        USP_RX_STOP: begin
          // stop level is not checked
          if (rx_ph_r == 4'd15) begin
            rx_st_r <= USP_RX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_full_r <= 1'b0;
      rx_data_r <= 8'h00;
    end else if (rx_done) begin
      rx_full_r <= 1'b1;
      rx_data_r <= rx_sh_r;
    end else if (rx_take) begin
      rx_full_r <= 1'b0;
    end
  end
  assign receive_full_flag = rx_full_r;
  assign received_byte_bits = rx_data_r;

  ////////////////////////////////////////////////////////////////////////////
  // edge interrupts
  logic rx_full_d_r;
  logic [1:0] irq_evt;

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_full_d_r <= 1'b0;
      tx_empty_d_r <= 1'b1;
    end else begin
      rx_full_d_r <= receive_full_flag;
      tx_empty_d_r <= transmit_empty_flag;
    end
  end
  assign irq_evt = {receive_full_flag && !rx_full_d_r, transmit_empty_flag && !tx_empty_d_r};

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat_r <= 2'h0;
    end else begin
      // set wins over clear
      irq_stat_r <= (irq_stat_r & ~((wr && addr == `USP_ADDR_IRQ_CLEAR) ? wdata[1:0] : 2'h0))
        | irq_evt;
    end
  end
  assign irq = |(irq_stat_r & irq_en_r);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_rx_evt;
    @(posedge clk) disable iff (rst) rx_done && !receive_full_flag |=> receive_full_flag ##1 irq_stat_r[1];
  endproperty
  a_rx_evt: assert property (p_rx_evt) else $error("receive event not flagged");

  property p_tx_evt;
    @(posedge clk) disable iff (rst) $rose(transmit_empty_flag) |=> irq_stat_r[0];
  endproperty
  a_tx_evt: assert property (p_tx_evt) else $error("transmit event not flagged");

  property p_flags_read;
    @(posedge clk) disable iff (rst) rd && addr == `USP_ADDR_FLAGS |=>
      rdata == {14'h0000, $past(receive_full_flag), $past(transmit_empty_flag)};
  endproperty
  a_flags_read: assert property (p_flags_read) else $error("flags read wrong");

  property p_data_read;
    @(posedge clk) disable iff (rst) rd && addr == `USP_ADDR_DATA |=>
      rdata[15:8] == 8'h00 && rdata[7:0] == $past(rx_data_r);
  endproperty
  a_data_read: assert property (p_data_read) else $error("data read wrong");

  property p_load;
    @(posedge clk) disable iff (rst) tx_load |=> !transmit_empty_flag && tx_hold_r == $past(wdata[7:0]);
  endproperty
  a_load: assert property (p_load) else $error("transmit load lost");

  property p_ctl;
    @(posedge clk) disable iff (rst) wr && addr == `USP_ADDR_CONTROL && wdata == 16'h000b |=>
      port_enable && rate_select == 3'd5 && !rate_prescale_eighth;
  endproperty
  a_ctl: assert property (p_ctl) else $error("control fields wrong");

  property p_start_low;
    @(posedge clk) disable iff (rst) tx_st_r == USP_TX_START |-> !gpio28_txd;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");

  property p_idle_high;
    @(posedge clk) disable iff (rst) tx_st_r == USP_TX_IDLE ##1 tx_st_r == USP_TX_IDLE |-> gpio28_txd;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle line not high");

  property p_tick_rate;
    @(posedge clk) disable iff (rst) tick |-> tick_div >= 16'd67; // floor at 115200 x16
  endproperty
  a_tick_rate: assert property (p_tick_rate) else $error("baud tick too fast");
endmodule

//--- usp_cfg.svh
// register offsets, field positions, reset values and timing counts of the serial port
`ifndef USP_CFG_SVH
`define USP_CFG_SVH
`define USP_ADDR_CONTROL 16'hc0e0
`define USP_ADDR_FLAGS 16'hc0e2
`define USP_ADDR_DATA 16'hc0e4
`define USP_ADDR_IRQ_STATUS 16'hc0e6
`define USP_ADDR_IRQ_CLEAR 16'hc0e8
`define USP_ADDR_IRQ_ENABLE 16'hc0ea
`define USP_CTL_ENABLE_BIT 0
`define USP_CTL_RATE_LSB 1
`define USP_CTL_RATE_MSB 3
`define USP_CTL_PRESCALE_BIT 4
`define USP_FLG_TX_EMPTY_BIT 0
`define USP_FLG_RX_FULL_BIT 1
`define USP_CTL_RESET 5'h00
`define USP_CLK_HZ 125000000
`define USP_BAUD_MAX_HZ 115200
`define USP_BAUD_MIN_HZ 7200
`define USP_BIT_CYCLES_MAX (`USP_CLK_HZ / `USP_BAUD_MAX_HZ)
`define USP_PRESCALE 8
`endif

//--- usp_pkg.sv
// types shared by the serial port
package usp_pkg;
  typedef enum logic [3:0] {
    USP_TX_IDLE = 4'b0001,
    USP_TX_START = 4'b0010,
    USP_TX_DATA = 4'b0100,
    USP_TX_STOP = 4'b1000
  } usp_tx_state_t;
  typedef enum logic [3:0] {
    USP_RX_IDLE = 4'b0001,
    USP_RX_START = 4'b0010,
    USP_RX_DATA = 4'b0100,
    USP_RX_STOP = 4'b1000
  } usp_rx_state_t;
endpackage

//--- usp_host_model.sv
// serial terminal model on the far side of the port
`timescale 1ns/1ps
module usp_host_model (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  int bit_cyc = 1072;
  int bad_stop = 0;
  int run = 0;
  int last_low = 0;
  logic [7:0] got_q[$];
  initial rxd = 1'b1;
  ////////////////////////////////////////////////////////////////
  // send one frame, lsb first, then leave the line high
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (bit_cyc) @(posedge clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // capture frames by sampling at mid-bit
  always begin : capture
    logic [7:0] b;
    @(negedge txd);
    repeat (bit_cyc / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge clk);
      b[i] = txd;
    end
    repeat (bit_cyc) @(posedge clk);
    if (txd !== 1'b1) bad_stop++;
    got_q.push_back(b);
  end
  // length of the first low run after last_low is cleared
  always @(posedge clk) begin
    if (txd === 1'b0) run++;
    else begin
      if (run != 0 && last_low == 0) last_low = run;
      run = 0;
    end
  end
endmodule

//--- usp_serial_port_bench.sv
// self-checking bench of the serial port
`timescale 1ns/1ps
`include "usp_cfg.svh"
module usp_serial_port_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic irq;
  logic txd;
  logic rxd;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] seed = 32'hc75f;
  logic [15:0] v;
  logic [15:0] rv;
  logic [7:0] b;
  logic [7:0] exp_q[$];
  always #4 clk = ~clk;
  usp_serial_port usp_serial_port_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .gpio28_txd(txd), .gpio27_rxd(rxd));
  usp_host_model usp_host_model_inst (.clk(clk), .txd(txd), .rxd(rxd));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // bit length in clock cycles: sixteen ticks of the truncated tick period
  function automatic int bitc(input int code, input int pre);
    int r[8] = '{115200, 57600, 38400, 28800, 19200, 14400, 9600, 7200};
    return 16 * (125000000 / (r[code] * 16)) * (pre ? 8 : 1);
  endfunction
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_tx_empty();
    logic [15:0] f;
    for (int n = 0; n < 15000; n++) begin
      rd_reg(`USP_ADDR_FLAGS, f);
      if (f[0] === 1'b1) break;
    end
  endtask
  task automatic wait_got(input int k);
    for (int n = 0; n < 40000 && usp_host_model_inst.got_q.size() < k; n++) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (cyc == 99000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`USP_ADDR_CONTROL, v);
    chk(16'h0000, v);
    rd_reg(`USP_ADDR_FLAGS, v);
    chk(16'h0001, v);
    rd_reg(16'hc0ee, v);
    chk(16'h0000, v);
    chk(16'h0000, {15'h0000, irq});
    for (int c = 0; c < 8; c++) begin
      v = 16'(xs());
      v[3:0] = {c[2:0], 1'b0};
      wr_reg(`USP_ADDR_CONTROL, v);
      rd_reg(`USP_ADDR_CONTROL, rv);
      chk(v & 16'h001f, rv);
    end
    wr_reg(`USP_ADDR_IRQ_ENABLE, 16'h0003);
    wr_reg(`USP_ADDR_CONTROL, 16'h0001);
    wr_reg(`USP_ADDR_IRQ_CLEAR, 16'h0003);
    // second byte waits in the holding byte while the first shifts out
    for (int i = 0; i < 2; i++) begin
      v = 16'(xs());
      exp_q.push_back(v[7:0]);
      wr_reg(`USP_ADDR_DATA, v);
      wait_tx_empty();
    end
    #1 chk(16'h0001, {15'h0000, irq});
    wr_reg(`USP_ADDR_IRQ_CLEAR, 16'h0001);
    #1 chk(16'h0000, {15'h0000, irq});
    wait_got(2);
    for (int i = 0; i < 2; i++) begin
      b = (usp_host_model_inst.got_q.size() > 0) ? usp_host_model_inst.got_q.pop_front() : 8'hxx;
      chk({8'h00, exp_q[i]}, {8'h00, b});
    end
    chk(16'h0000, usp_host_model_inst.bad_stop[15:0]);
    b = 8'(xs());
    usp_host_model_inst.send(b);
    repeat (8) @(posedge clk);
    rd_reg(`USP_ADDR_FLAGS, v);
    chk(16'h0003, v);
    rd_reg(`USP_ADDR_IRQ_STATUS, v);
    chk(16'h0002, v);
    rd_reg(`USP_ADDR_DATA, v);
    chk({8'h00, b}, v);
    rd_reg(`USP_ADDR_FLAGS, v);
    chk(16'h0001, v);
    wr_reg(`USP_ADDR_IRQ_CLEAR, 16'h0002);
    #1 chk(16'h0000, {15'h0000, irq});
    // unread byte is overwritten with no error flag
    usp_host_model_inst.send(8'(xs()));
    b = 8'(xs());
    usp_host_model_inst.send(b);
    repeat (8) @(posedge clk);
    rd_reg(`USP_ADDR_FLAGS, v);
    chk(16'h0003, v);
    rd_reg(`USP_ADDR_DATA, v);
    chk({8'h00, b}, v);
    // start bit length at 57.6K, then at 14.4K from control 0x000b
    wr_reg(`USP_ADDR_CONTROL, 16'h0003);
    usp_host_model_inst.bit_cyc = bitc(1, 0);
    usp_host_model_inst.last_low = 0;
    b = 8'(xs() | 32'h1);
    wr_reg(`USP_ADDR_DATA, {8'h00, b});
    wait_got(1);
    chk({8'h00, b}, {8'h00, usp_host_model_inst.got_q.pop_front()});
    chk(bitc(1, 0), usp_host_model_inst.last_low);
    // disable first so the stop bit in flight does not stretch at the new rate
    wr_reg(`USP_ADDR_CONTROL, 16'h0000);
    wr_reg(`USP_ADDR_CONTROL, 16'h000b);
    usp_host_model_inst.bit_cyc = bitc(5, 0);
    usp_host_model_inst.last_low = 0;
    wr_reg(`USP_ADDR_DATA, 16'h00ff);
    for (int n = 0; n < 20000 && usp_host_model_inst.last_low == 0; n++) @(posedge clk);
    chk(bitc(5, 0), usp_host_model_inst.last_low);
    // prescale divides the fastest rate by eight
    wr_reg(`USP_ADDR_CONTROL, 16'h0000);
    wr_reg(`USP_ADDR_CONTROL, 16'h0011);
    usp_host_model_inst.last_low = 0;
    wr_reg(`USP_ADDR_DATA, 16'h00ff);
    for (int n = 0; n < 20000 && usp_host_model_inst.last_low == 0; n++) @(posedge clk);
    chk(bitc(0, 1), usp_host_model_inst.last_low);
    conclude();
  end
endmodule
